// ---- wmc_top.sv ----
// Purpose: Watchdog mode control with APB registers, interrupt and reset requests
// Assumes: Single core clock; core gives vector ack and global irq enable
// Notes: NRST acts as power-on reset; the watchdog reset request does not clear this block
`timescale 1ns/1ps
`default_nettype none
module wmc_top #(
	parameter int WD_DIV = wmc_pkg::WMC_OSC_DIV
) (
	input wire logic MCLK,
	input wire logic NRST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic WD_FUSE_N,
	input wire logic GLOBAL_IRQ_EN,
	input wire logic VECTOR_ACK,
	input wire logic WDR_STROBE,
	output logic WD_IRQ,
	output logic WD_RESET_REQ,
	output logic [11:0] RST_VECTOR,
	output logic IRQ
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	wmc_pkg::wmc_ctrl_t ctrl_q;
	wmc_pkg::wmc_ctrl_t ctrl_d;
	wmc_pkg::wmc_apb_state_t apb_q;
	wmc_pkg::wmc_apb_state_t apb_d;
	logic [2:0] chg_cnt_q;
	logic [2:0] chg_cnt_d;
	logic rst_flag_q;
	logic rst_flag_d;
	logic [1:0] istat_q;
	logic [1:0] istat_d;
	logic [1:0] imask_q;
	logic [1:0] imask_d;
	logic [31:0] rdata_d;
	logic fuse_n;
	logic timeout;
	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	wire acc = PSEL && PENABLE && (apb_q == wmc_pkg::WMC_APB_WAIT);
	wire done = PSEL && PENABLE && PREADY;
	wire sel_ctrl = (PADDR == wmc_pkg::WMC_OFS_CTRL);
	wire sel_cause = (PADDR == wmc_pkg::WMC_OFS_CAUSE);
	wire sel_istat = (PADDR == wmc_pkg::WMC_OFS_ISTAT);
	wire sel_imask = (PADDR == wmc_pkg::WMC_OFS_IMASK);
	wire sel_cmd = (PADDR == wmc_pkg::WMC_OFS_CMD);
	wire mapped = sel_ctrl || sel_cause || sel_istat || sel_imask || sel_cmd;
	wire wr = done && PWRITE && mapped;
	// Reads act on the data capture edge, so read-to-clear cannot drop an event landing in between
	wire rd = acc && !PWRITE && mapped;
	wire wr_ctrl = wr && sel_ctrl;
	wire wr_cause = wr && sel_cause;
	wire wr_imask = wr && sel_imask;
	wire wr_cmd = wr && sel_cmd;
	wire rd_istat = rd && sel_istat;
	// Written control fields
	wire w_flag = PWDATA[wmc_pkg::WMC_B_IRQ_FLAG];
	wire w_ien = PWDATA[wmc_pkg::WMC_B_IRQ_EN];
	wire w_chg = PWDATA[wmc_pkg::WMC_B_CHG_EN];
	wire w_rst = PWDATA[wmc_pkg::WMC_B_RST_EN];
	wire [3:0] w_psel = {PWDATA[wmc_pkg::WMC_B_PSEL3], PWDATA[wmc_pkg::WMC_B_PSEL_LO +: 3]};
	// ------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------
	// Protected changes are open while the window counter runs
	wire chg_open = (chg_cnt_q != 3'h0);
	// Programmed fuse locks the enables to reset mode
	wire fuse_forced = !fuse_n;
	wire rst_en_eff = ctrl_q.rst_en || rst_flag_q || fuse_forced;
	wire irq_en_eff = ctrl_q.irq_en && !fuse_forced;
	// Mode table with the fuse unprogrammed
	wire stopped = !fuse_forced && !rst_en_eff && !irq_en_eff;
	wire mode_reset_only = rst_en_eff && !irq_en_eff;
	wire mode_combined = rst_en_eff && irq_en_eff;
	// Combined mode escalates when the earlier interrupt was never serviced
	wire escalate = mode_combined && ctrl_q.irq_flag;
	// Reset on time-out: fuse forced, reset-only, or escalation
	wire do_reset = timeout && (fuse_forced || mode_reset_only || escalate);
	// Otherwise an enabled interrupt just sets the flag
	wire do_flag = timeout && irq_en_eff && !do_reset;
	// Restart from the command register or the restart instruction
	wire sw_restart = wr_cmd && PWDATA[wmc_pkg::WMC_B_CMD_RESTART];
	wire restart = sw_restart || WDR_STROBE;
	// Timer runs unless stopped and starts over after every reset request
	wire timer_run = !stopped;
	wire timer_clear = restart || do_reset;
	wire [7:0] ctrl_rd = {ctrl_q.irq_flag, irq_en_eff, ctrl_q.psel[3], chg_open,
		rst_en_eff, ctrl_q.psel[2:0]};
	wire [1:0] ev = {do_reset, do_flag};
	// ------------------------------------------------------------
	// Input crossing and time-out counter
	// ------------------------------------------------------------
	wmc_sync #(
		.RST_VAL(1'b0)
	) u_fuse_sync (
		.clk(MCLK),
		.rst_n(NRST),
		.d(WD_FUSE_N),
		.q(fuse_n)
	);
	wmc_timer #(
		.DIV(WD_DIV)
	) u_timer (
		.clk(MCLK),
		.rst_n(NRST),
		.run(timer_run),
		.restart(timer_clear),
		.sel(ctrl_q.psel),
		.timeout(timeout)
	);
	// ------------------------------------------------------------
	// APB handshake: one wait state, then ready
	// ------------------------------------------------------------
	always_comb begin
		case (apb_q)
			wmc_pkg::WMC_APB_IDLE: apb_d = (PSEL && !PENABLE) ? wmc_pkg::WMC_APB_WAIT : wmc_pkg::WMC_APB_IDLE;
			wmc_pkg::WMC_APB_WAIT: apb_d = acc ? wmc_pkg::WMC_APB_DONE : wmc_pkg::WMC_APB_WAIT;
			wmc_pkg::WMC_APB_DONE: apb_d = wmc_pkg::WMC_APB_IDLE;
			default: apb_d = wmc_pkg::WMC_APB_IDLE;
		endcase
	end
	// Read data mux, captured with ready
	always_comb begin
		rdata_d = 32'h00000000;
		if (sel_ctrl) begin
			rdata_d[7:0] = ctrl_rd;
		end else if (sel_cause) begin
			rdata_d[wmc_pkg::WMC_B_WD_RST_FLAG] = rst_flag_q;
		end else if (sel_istat) begin
			rdata_d[1:0] = istat_q;
		end else if (sel_imask) begin
			rdata_d[1:0] = imask_q;
		end
	end
	// ------------------------------------------------------------
	// Control register next state
	// ------------------------------------------------------------
	always_comb begin
		ctrl_d = ctrl_q;
		chg_cnt_d = chg_open ? 3'(chg_cnt_q - 3'h1) : 3'h0;
		if (wr_ctrl) begin
			ctrl_d.irq_en = w_ien;
			if (w_rst) begin
				ctrl_d.rst_en = 1'b1;
			end else if (chg_open) begin
				ctrl_d.rst_en = 1'b0;
			end
			if (chg_open) begin
				ctrl_d.psel = w_psel;
			end
			chg_cnt_d = w_chg ? wmc_pkg::WMC_CHG_CYCLES : 3'h0;
			if (w_flag) begin
				ctrl_d.irq_flag = 1'b0;
			end
		end
		if (VECTOR_ACK) begin
			ctrl_d.irq_en = 1'b0;
			ctrl_d.irq_flag = 1'b0;
		end
		if (rst_flag_q) begin
			ctrl_d.rst_en = 1'b1;
		end
		if (do_flag) begin
			ctrl_d.irq_flag = 1'b1;
		end
	end
	// Reset cause flag: set wins over the software clear
	assign rst_flag_d = do_reset || (rst_flag_q && !(wr_cause && !PWDATA[wmc_pkg::WMC_B_WD_RST_FLAG]));
	// Sticky events, cleared by reading, set wins
	assign istat_d = ev | (rd_istat ? 2'b00 : istat_q);
	assign imask_d = wr_imask ? PWDATA[1:0] : imask_q;
	// ------------------------------------------------------------
	// Output next values
	// ------------------------------------------------------------
	// Ready and error answer the access phase after one wait state
	wire pready_d = acc;
	wire pslverr_d = acc && !mapped;
	// Read data is zero outside the ready cycle of a read
	wire [31:0] prdata_d = (acc && !PWRITE) ? rdata_d : 32'h00000000;
	// Uses the next flag and enable so a vector ack drops the request at once
	wire wd_irq_d = ctrl_d.irq_flag && ctrl_d.irq_en && fuse_n && GLOBAL_IRQ_EN;
	// Summary line from sticky events under the mask
	wire irq_d = |(istat_d & imask_d);
	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	// Control byte
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			ctrl_q <= '{irq_flag: 1'b0, irq_en: 1'b0, rst_en: 1'b0, psel: wmc_pkg::WMC_PSEL_RST};
		end else begin
			ctrl_q <= ctrl_d;
		end
	end
	// Change-enable window counter
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			chg_cnt_q <= 3'h0;
		end else begin
			chg_cnt_q <= chg_cnt_d;
		end
	end
	// Reset cause flag; NRST stands for the power-on reset
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			rst_flag_q <= 1'b0;
		end else begin
			rst_flag_q <= rst_flag_d;
		end
	end
	// Sticky event status and its mask
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			istat_q <= 2'b00;
			imask_q <= 2'b00;
		end else begin
			istat_q <= istat_d;
			imask_q <= imask_d;
		end
	end
	// Bus handshake state
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			apb_q <= wmc_pkg::WMC_APB_IDLE;
		end else begin
			apb_q <= apb_d;
		end
	end
	// ------------------------------------------------------------
	// Registered outputs
	// ------------------------------------------------------------
	// Bus answer, one cycle wide
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			PREADY <= 1'b0;
			PRDATA <= 32'h00000000;
			PSLVERR <= 1'b0;
		end else begin
			PREADY <= pready_d;
			PRDATA <= prdata_d;
			PSLVERR <= pslverr_d;
		end
	end
	// Watchdog requests and summary interrupt
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			WD_IRQ <= 1'b0;
			WD_RESET_REQ <= 1'b0;
			IRQ <= 1'b0;
		end else begin
			WD_IRQ <= wd_irq_d;
			WD_RESET_REQ <= do_reset;
			IRQ <= irq_d;
		end
	end
	// Reset vector held in a flop so the pins carry no logic
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			RST_VECTOR <= wmc_pkg::WMC_RESET_VECTOR;
		end else begin
			RST_VECTOR <= wmc_pkg::WMC_RESET_VECTOR;
		end
	end
endmodule : wmc_top
`default_nettype wire

// ---- wmc_pkg.sv ----
// Purpose: Shared constants and types for the watchdog mode control block
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: Control bit positions follow the control/status byte layout
package wmc_pkg;
	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] WMC_OFS_CTRL = 8'h00;
	localparam logic [7:0] WMC_OFS_CAUSE = 8'h04;
	localparam logic [7:0] WMC_OFS_ISTAT = 8'h08;
	localparam logic [7:0] WMC_OFS_IMASK = 8'h0c;
	localparam logic [7:0] WMC_OFS_CMD = 8'h10;
	// ------------------------------------------------------------
	// Control/status byte fields
	// ------------------------------------------------------------
	localparam int WMC_B_IRQ_FLAG = 7;
	localparam int WMC_B_IRQ_EN = 6;
	localparam int WMC_B_PSEL3 = 5;
	localparam int WMC_B_CHG_EN = 4;
	localparam int WMC_B_RST_EN = 3;
	localparam int WMC_B_PSEL_LO = 0;
	// Reset cause register: watchdog reset flag position
	localparam int WMC_B_WD_RST_FLAG = 3;
	// Interrupt status/mask bits
	localparam int WMC_B_EV_TIMEOUT_IRQ = 0;
	localparam int WMC_B_EV_SYS_RESET = 1;
	localparam int WMC_EV_W = 2;
	// Command register bits
	localparam int WMC_B_CMD_RESTART = 0;
	// ------------------------------------------------------------
	// Reset values and timing
	// ------------------------------------------------------------
	localparam logic [3:0] WMC_PSEL_RST = 4'h0;
	localparam logic [3:0] WMC_PSEL_MAX = 4'h9;
	localparam logic [20:0] WMC_BASE_CYCLES = 21'h000800;
	localparam logic [2:0] WMC_CHG_CYCLES = 3'h4;
	localparam logic [11:0] WMC_RESET_VECTOR = 12'h000;
	localparam int WMC_CLK_KHZ = 200000;
	localparam int WMC_OSC_KHZ = 128;
	localparam int WMC_OSC_DIV = WMC_CLK_KHZ / WMC_OSC_KHZ;
	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic irq_flag;
		logic irq_en;
		logic rst_en;
		logic [3:0] psel;
	} wmc_ctrl_t;
	typedef enum logic [1:0] {
		WMC_APB_IDLE = 2'b00,
		WMC_APB_WAIT = 2'b01,
		WMC_APB_DONE = 2'b10
	} wmc_apb_state_t;
endpackage : wmc_pkg

// ---- wmc_sync.sv ----
// Purpose: Two-flop synchroniser for asynchronous level inputs
// Assumes: Input is a slowly changing level such as a fuse strap
// Notes: First stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module wmc_sync #(
	parameter logic RST_VAL = 1'b0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic d,
	output logic q
);
	logic meta_q;
	// ------------------------------------------------------------
	// Synchroniser chain
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= RST_VAL;
			q <= RST_VAL;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule : wmc_sync
`default_nettype wire

// ---- wmc_timer.sv ----
// Purpose: Watchdog oscillator tick divider and time-out counter
// Assumes: Oscillator rate is an enable pulse divided from the core clock
// Notes: Counter is held cleared while not running
`timescale 1ns/1ps
`default_nettype none
module wmc_timer #(
	parameter int DIV = wmc_pkg::WMC_OSC_DIV,
	parameter int DW = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic restart,
	input wire logic [3:0] sel,
	output logic timeout
);
	logic [DW-1:0] div_q;
	logic [19:0] cnt_q;
	logic [3:0] sel_c;
	logic [20:0] limit;
	logic [19:0] last;
	logic tick;
	logic hit;
	// ------------------------------------------------------------
	// Period select
	// ------------------------------------------------------------
	// Reserved codes fall back to the longest period
	assign sel_c = (sel > wmc_pkg::WMC_PSEL_MAX) ? wmc_pkg::WMC_PSEL_MAX : sel;
	assign limit = wmc_pkg::WMC_BASE_CYCLES << sel_c;
	assign last = 20'(limit - 21'h000001);
	assign tick = (div_q == DW'(DIV - 1));
	assign hit = tick && (cnt_q == last);
	// ------------------------------------------------------------
	// Oscillator enable divider and counter
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_q <= '0;
			cnt_q <= '0;
			timeout <= 1'b0;
		end else if (!run || restart) begin
			div_q <= '0;
			cnt_q <= '0;
			timeout <= 1'b0;
		end else begin
			div_q <= tick ? '0 : DW'(div_q + 1'b1);
			if (tick) begin
				cnt_q <= hit ? '0 : 20'(cnt_q + 1'b1);
			end
			timeout <= hit;
		end
	end
endmodule : wmc_timer
`default_nettype wire

// ---- wmc_properties.sv ----
// Purpose: Port assertions for the watchdog mode control block
// Assumes: One core clock, NRST asynchronous active low
// Notes: Bound to wmc_top by the statement after the module
`timescale 1ns/1ps
`default_nettype none
module wmc_properties (
	input wire logic MCLK,
	input wire logic NRST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic GLOBAL_IRQ_EN,
	input wire logic VECTOR_ACK,
	input wire logic WD_IRQ,
	input wire logic WD_RESET_REQ,
	input wire logic [11:0] RST_VECTOR
);
	// ------------------------------------------------------------
	// Bus and request checks
	// ------------------------------------------------------------
	default clocking @(posedge MCLK); endclocking
	default disable iff (!NRST);
	a_ready_wait: assert property ((PSEL && !PENABLE) ##1 (PSEL && PENABLE) |=> PREADY)
		else $error("ready not after one wait state");
	a_ready_single: assert property (PREADY |=> !PREADY)
		else $error("ready held too long");
	a_err_ready: assert property (PSLVERR |-> PREADY)
		else $error("error without ready");
	a_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0)
		else $error("read data outside ready");
	a_irq_gate: assert property (WD_IRQ |-> $past(GLOBAL_IRQ_EN))
		else $error("irq without global enable");
	a_ack_clears: assert property (VECTOR_ACK |=> !WD_IRQ)
		else $error("irq kept after vectoring");
	a_reset_pulse: assert property (WD_RESET_REQ |=> !WD_RESET_REQ)
		else $error("reset request longer than a pulse");
	a_vector_zero: assert property (WD_RESET_REQ |-> RST_VECTOR == 12'h000)
		else $error("reset vector not zero");
endmodule : wmc_properties
bind wmc_top wmc_properties u_props (.MCLK(MCLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
	.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN),
	.VECTOR_ACK(VECTOR_ACK), .WD_IRQ(WD_IRQ), .WD_RESET_REQ(WD_RESET_REQ), .RST_VECTOR(RST_VECTOR));
`default_nettype wire

// ---- tb.sv ----
// Purpose: Self-checking bench for wmc_top
// Assumes: WD_DIV of 1, so one oscillator tick per core clock
// Notes: Time-out at prescale code 0 is 2048 core cycles
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic MCLK = 1'h0;
	logic NRST = 1'h0;
	logic PSEL = 1'h0;
	logic PENABLE = 1'h0;
	logic PWRITE = 1'h0;
	logic [7:0] PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0;
	logic WD_FUSE_N = 1'h1;
	logic GLOBAL_IRQ_EN = 1'h0;
	logic VECTOR_ACK = 1'h0;
	logic WDR_STROBE = 1'h0;
	logic [31:0] PRDATA, rd;
	logic PREADY, PSLVERR, WD_IRQ, WD_RESET_REQ, IRQ, er;
	logic [11:0] RST_VECTOR;
	int mismatches = 0;
	int tests_run = 0;
	int rst_cnt = 0;
	int i;
	wmc_top #(.WD_DIV(1)) u_wmc_top (.MCLK(MCLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .WD_FUSE_N(WD_FUSE_N), .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN),
		.VECTOR_ACK(VECTOR_ACK), .WDR_STROBE(WDR_STROBE), .WD_IRQ(WD_IRQ),
		.WD_RESET_REQ(WD_RESET_REQ), .RST_VECTOR(RST_VECTOR), .IRQ(IRQ));
	// Clock and count of reset request pulses
	always #2.5 MCLK = ~MCLK;
	always @(posedge MCLK) if (WD_RESET_REQ === 1'h1) rst_cnt <= rst_cnt + 1;
	// ------------------------------------------------------------
	// Bus tasks
	// ------------------------------------------------------------
	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (s !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask : cmp
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge MCLK);
		PSEL <= 1'h1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge MCLK);
		PENABLE <= 1'h1;
		do @(posedge MCLK); while (PREADY !== 1'h1);
		rd = PRDATA;
		er = PSLVERR;
		PSEL <= 1'h0;
		PENABLE <= 1'h0;
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'h1, a, d);
	endtask : wr
	task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		xfer(1'h0, a, 32'h0);
		cmp(n, e, rd & m);
	endtask : rdc
	task automatic wait_irq();
		for (i = 0; i < 3000 && WD_IRQ !== 1'h1; i++) @(posedge MCLK);
	endtask : wait_irq
	task automatic wait_rst(input int n0);
		for (i = 0; i < 3000 && rst_cnt == n0; i++) @(posedge MCLK);
	endtask : wait_rst
	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : complete_run
	// Hang guard
	initial begin
		#(40000 * 5);
		mismatches++;
		complete_run();
	end
	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		int n0;
		repeat (8) @(posedge MCLK);
		NRST <= 1'h1;
		repeat (4) @(posedge MCLK);
		rdc("ctrl reset", 8'h00, 32'hff, 32'h00);
		rdc("cause reset", 8'h04, 32'hff, 32'h00);
		xfer(1'h0, 8'h14, 32'h0);
		cmp("unmapped err", 32'h1, {31'h0, er});
		$display("test reset done");
		wr(8'h00, 32'h08);
		wr(8'h00, 32'h00);
		rdc("rst_en kept", 8'h00, 32'hff, 32'h08);
		wr(8'h00, 32'h18);
		wr(8'h00, 32'h01);
		rdc("window change", 8'h00, 32'hff, 32'h01);
		wr(8'h00, 32'h19);
		repeat (6) @(posedge MCLK);
		rdc("window shut", 8'h00, 32'hff, 32'h09);
		wr(8'h00, 32'h23);
		rdc("psel kept", 8'h00, 32'hff, 32'h09);
		wr(8'h00, 32'h19);
		wr(8'h00, 32'h00);
		$display("test change window done");
		wr(8'h0c, 32'h3);
		GLOBAL_IRQ_EN <= 1'h1;
		n0 = rst_cnt;
		wr(8'h00, 32'h40);
		wait_irq();
		cmp("irq mode", 32'h1, {31'h0, WD_IRQ});
		cmp("irq line", 32'h1, {31'h0, IRQ});
		GLOBAL_IRQ_EN <= 1'h0;
		repeat (2) @(posedge MCLK);
		cmp("irq gated", 32'h0, {31'h0, WD_IRQ});
		GLOBAL_IRQ_EN <= 1'h1;
		rdc("istat flag", 8'h08, 32'h3, 32'h1);
		wr(8'h00, 32'hc0);
		rdc("flag cleared", 8'h00, 32'hff, 32'h40);
		wait_irq();
		cmp("no reset", n0, rst_cnt);
		VECTOR_ACK <= 1'h1;
		@(posedge MCLK);
		VECTOR_ACK <= 1'h0;
		rdc("ack clears", 8'h00, 32'hff, 32'h00);
		$display("test irq mode done");
		rdc("istat clear", 8'h08, 32'h3, 32'h1);
		wr(8'h00, 32'h48);
		wait_irq();
		cmp("first irq", n0, rst_cnt);
		wait_rst(n0);
		cmp("then reset", n0 + 1, rst_cnt);
		cmp("reset vector", {20'h0, wmc_pkg::WMC_RESET_VECTOR}, {20'h0, RST_VECTOR});
		cmp("irq line", 32'h1, {31'h0, IRQ});
		rdc("cause flag", 8'h04, 32'h08, 32'h08);
		rdc("istat both", 8'h08, 32'h3, 32'h3);
		wr(8'h00, 32'h18);
		wr(8'h00, 32'h00);
		rdc("flag holds en", 8'h00, 32'h08, 32'h08);
		wr(8'h04, 32'h0);
		rdc("cause clr", 8'h04, 32'h08, 32'h0);
		wr(8'h00, 32'h18);
		wr(8'h00, 32'h00);
		rdc("stop mode", 8'h00, 32'h48, 32'h00);
		$display("test combined done");
		n0 = rst_cnt;
		repeat (2100) @(posedge MCLK);
		cmp("stopped", n0, rst_cnt);
		WD_FUSE_N <= 1'h0;
		wr(8'h00, 32'h40);
		rdc("fuse forces", 8'h00, 32'h48, 32'h08);
		for (int k = 0; k < 3; k++) begin
			repeat (1500) @(posedge MCLK);
			WDR_STROBE <= 1'h1;
			@(posedge MCLK);
			WDR_STROBE <= 1'h0;
		end
		cmp("restart holds", n0, rst_cnt);
		repeat (1500) @(posedge MCLK);
		wr(8'h10, 32'h1);
		repeat (1000) @(posedge MCLK);
		cmp("cmd restart", n0, rst_cnt);
		wait_rst(n0);
		cmp("fuse reset", n0 + 1, rst_cnt);
		$display("test fuse done");
		complete_run();
	end
endmodule : tb
`default_nettype wire
